// [common/cgc_defs.vh]
// Register offsets, field positions, reset values and timing counts for the clock generator
`ifndef CGC_DEFS_VH
`define CGC_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CGC_OFS_MODE 4'h0
`define CGC_OFS_RUNSTOP 4'h1
`define CGC_OFS_STAB_STATUS 4'h2
`define CGC_OFS_STAB_SEL 4'h3
`define CGC_OFS_SYSCLK 4'h4
`define CGC_OFS_FAST_OSC 4'h5
`define CGC_OFS_SPEED 4'h6
`define CGC_OFS_REGULATOR 4'h7
`define CGC_OFS_PERIPH 4'h8
`define CGC_OFS_STATUS 4'h9

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CGC_MODE_HIGH_GAIN 0
`define CGC_RS_INT_STOP 0
`define CGC_RS_SUB_STOP 6
`define CGC_RS_MAIN_STOP 7
`define CGC_CK_DIV_LO 0
`define CGC_CK_DIV_HI 2
`define CGC_CK_MAIN_SEL 4
`define CGC_CK_CPU_SRC 6
`define CGC_FO_ENABLE 0
`define CGC_FO_SELECT 1
`define CGC_SP_FLASH_SPEED 0
`define CGC_SP_FLASH_LOW 1
`define CGC_SP_SUB_HALT_LP 7
`define CGC_PE_RTC 7

// ----------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------
`define CGC_RST_RUNSTOP 8'hc0
`define CGC_RST_STAB_SEL 8'h07
`define CGC_RST_SYSCLK 8'h09
`define CGC_RST_PERIPH 8'h00
`define CGC_REG_NORMAL 8'h00
`define CGC_REG_LOW 8'h5a
// Stall of 140.5 system clocks rounded up to whole cycles
`define CGC_STALL_HALF_CYCLES 9'd281
`define CGC_STALL_CYCLES 9'd141

`endif

// [dv/cgc_props.sv]
// Concurrent checks on the clock generator control ports
`timescale 1ns/1ns
`include "cgc_defs.vh"
module cgc_props (
	// Clock and bus
	input wire mclk,
	input wire rst,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [3:0] wb_adr_i,
	input wire [7:0] wb_dat_i,
	input wire wb_sel_i,
	input wire [7:0] wb_dat_o,
	input wire wb_ack_o,
	input wire wb_err_o,
	// Observed state
	input wire [7:0] osc_mode_config,
	input wire main_osc_high_gain,
	input wire cpu_stall,
	input wire flash_low_power_mode
);
	wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wr = req && wb_we_i && wb_sel_i;
	reg mode_done;
	reg [8:0] stall_len;
	always @(posedge mclk)
	begin
		mode_done <= !rst && (mode_done || (wr && wb_adr_i == `CGC_OFS_MODE));
		stall_len <= (cpu_stall && !rst) ? stall_len + 9'd1 : 9'd0;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_mode_first;
		wr && !mode_done && wb_adr_i == `CGC_OFS_MODE;
	endsequence
	sequence s_stall_go;
		wr && wb_adr_i == `CGC_OFS_SPEED && wb_dat_i[0];
	endsequence
	a_ack_next: assert property (req |=> wb_ack_o) else $error("ack late");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	a_err_quiet: assert property (!wb_err_o) else $error("err raised");
	a_unmapped_zero: assert property (req && !wb_we_i && wb_adr_i > `CGC_OFS_STATUS
		|=> wb_dat_o == 8'h00) else $error("unmapped data");
	a_mode_first: assert property (s_mode_first
		|=> osc_mode_config == $past(wb_dat_i)) else $error("mode not taken");
	a_mode_locked: assert property (mode_done |=> $stable(osc_mode_config))
		else $error("mode rewritten");
	a_gain_bit: assert property (main_osc_high_gain == osc_mode_config[0])
		else $error("gain mismatch");
	a_stall_start: assert property (s_stall_go |=> cpu_stall [*8])
		else $error("stall missing");
	a_stall_length: assert property ($fell(cpu_stall) |-> stall_len == 9'd141)
		else $error("stall length");
	a_flash_low_sticky: assert property (flash_low_power_mode |=> flash_low_power_mode)
		else $error("low power cleared");
endmodule // cgc_props
bind cgc_clock_generator_control cgc_props u_props (.mclk, .rst, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .wb_err_o,
	.osc_mode_config, .main_osc_high_gain, .cpu_stall, .flash_low_power_mode);

// [dv/tb.sv]
// Self-checking bench for the clock generator control block
`timescale 1ns/1ns
module tb;
	reg mclk = 0;
	reg rst = 1;
	reg wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, stop_release = 0, sub_halt = 0;
	reg [3:0] wb_adr_i = 0;
	reg [7:0] wb_dat_i = 0, rnd;
	wire [7:0] wb_dat_o, osc_mode_config;
	wire [2:0] main_divider_field;
	wire wb_ack_o, cpu_stall, flash_low_power_mode, periph_clock_enable;
	wire cpu_source_select, main_source_select, main_osc_high_gain, fast_internal_enable;
	integer n_errors = 0, comparisons = 0, cycles = 0, seed = 61715;
	reg [7:0] q[$];
	cgc_clock_generator_control u_cgc_clock_generator_control (.mclk, .rst, .wb_cyc_i,
		.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i(1'b1), .wb_dat_o, .wb_ack_o,
		.wb_err_o(), .main_osc_stop(), .sub_osc_stop(), .internal_osc_stop(),
		.main_osc_high_gain, .osc_mode_config, .fast_internal_enable,
		.fast_internal_select(), .main_osc_tick(1'b1), .stop_release,
		.cpu_source_select, .main_source_select, .main_divider_field,
		.periph_clock_enable, .rtc_clock_enable(), .peripheral_enable(), .sub_halt,
		.cpu_stall, .flash_speed_mode(), .flash_low_power_mode,
		.sub_halt_low_power(), .regulator_mode());
	initial forever #20 mclk = ~mclk;
	task summarize;
	begin
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask
	task chk(input string nm, input [7:0] e, input [7:0] g);
	begin
		comparisons = comparisons + 1;
		if (g !== e)
		begin
			n_errors = n_errors + 1;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	end
	endtask
	task bus(input [3:0] a, input w, input [7:0] d);
	begin
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		@(posedge mclk);
		while (wb_ack_o !== 1'b1) @(posedge mclk);
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
		@(posedge mclk);
	end
	endtask
	task rd(input [3:0] a, input [7:0] e);
	begin
		q.push_back(e);
		bus(a, 0, 8'h00);
	end
	endtask
	// Read data is judged against the oldest noted expectation
	always @(posedge mclk)
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
			chk("rdata", q.pop_front(), wb_dat_o);
	always @(posedge mclk)
	begin
		cycles = cycles + 1;
		if (cycles == 4000)
		begin
			n_errors = n_errors + 1;
			summarize;
		end
	end
	initial
	begin
		repeat (4) @(posedge mclk);
		rst <= 0;
		@(posedge mclk);
		rd(4'h1, 8'hc0);
		rd(4'h3, 8'h07);
		rd(4'h4, 8'h09);
		rd(4'hf, 8'h00);
		$display("test reset done");
		bus(4'h0, 1, 8'h01);
		bus(4'h0, 1, 8'h00);
		chk("mode", 8'h01, osc_mode_config);
		// default still needs its one write
		chk("gain", 8'h01, main_osc_high_gain);
		rd(4'h9, 8'h01);
		rnd = $random(seed);
		bus(4'h7, 1, rnd);
		rd(4'h7, rnd);
		bus(4'h7, 1, 8'h00);
		bus(4'h4, 1, 8'h55);
		chk("clksel", 8'h55, {1'b0, cpu_source_select, 1'b0, main_source_select,
			1'b0, main_divider_field});
		$display("test regs done");
		bus(4'h6, 1, 8'h01);
		repeat (135) @(posedge mclk);
		#1 chk("stall", 8'h01, cpu_stall);
		repeat (10) @(posedge mclk);
		#1 chk("stall", 8'h00, cpu_stall);
		@(posedge mclk);
		// regulator in low mode for flash_low_power_mode
		bus(4'h7, 1, 8'h5a);
		// flash speed cleared at low clock
		bus(4'h6, 1, 8'h82);
		sub_halt <= 1;
		@(posedge mclk);
		#1 chk("pclk", 8'h00, periph_clock_enable);
		@(posedge mclk);
		sub_halt <= 0;
		bus(4'h6, 1, 8'h00);
		chk("flash_low_power_mode", 8'h01, flash_low_power_mode);
		$display("test power done");
		bus(4'h5, 1, 8'h01);
		chk("fosc", 8'h01, fast_internal_enable);
		// select left clear, no wait modelled
		rd(4'h5, 8'h01);
		bus(4'h3, 1, 8'h01);
		bus(4'h1, 1, 8'h00);
		rd(4'h2, 8'h00);
		repeat (1200) @(posedge mclk);
		// status read before clock relied on
		rd(4'h2, 8'h03);
		stop_release <= 1;
		@(posedge mclk);
		stop_release <= 0;
		rd(4'h2, 8'h00);
		$display("test stabilization done");
		summarize;
	end
endmodule // tb

// [rtl/cgc_clock_generator_control.v]
// Clock generator control: oscillator mode, stabilization counter, clock select, speed mode
//
// Implementation choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ns
`include "cgc_defs.vh"
// What this block does
// - Mode register takes first byte write only
// - Status bits set in order, stay set until oscillator stop or STOP release restarts the wait
// - Counter stops at selected stabilization time
// - Selected clock feeds CPU and peripherals
// - Flash speed write stalls CPU 141 cycles (140.5 rounded up)
// - Flash low-power bit cleared only by reset
module cgc_clock_generator_control #(
	parameter STAB_W = 19
)(
	// Clock and reset
	input wire mclk,
	input wire rst,
	// Wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [3:0] wb_adr_i,
	input wire [7:0] wb_dat_i,
	input wire wb_sel_i,
	output reg [7:0] wb_dat_o,
	output reg wb_ack_o,
	output wire wb_err_o,
	// Oscillator controls
	output reg main_osc_stop,
	output reg sub_osc_stop,
	output reg internal_osc_stop,
	output reg main_osc_high_gain,
	output reg [7:0] osc_mode_config,
	output reg fast_internal_enable,
	output reg fast_internal_select,
	// Oscillator stabilization inputs
	input wire main_osc_tick,
	input wire stop_release,
	// Clock routing
	output reg cpu_source_select,
	output reg main_source_select,
	output reg [2:0] main_divider_field,
	output reg periph_clock_enable,
	output reg rtc_clock_enable,
	output reg [6:0] peripheral_enable,
	// CPU and power state
	input wire sub_halt,
	output wire cpu_stall,
	output reg flash_speed_mode,
	output reg flash_low_power_mode,
	output reg sub_halt_low_power,
	output reg [7:0] regulator_mode
);

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	wire req;
	wire wr;
	reg mode_written;
	reg [7:0] run_stop;
	reg [7:0] stab_sel;
	reg [7:0] sysclk;
	reg [7:0] stab_status;
	reg [STAB_W-1:0] stab_count;
	reg [8:0] stall_count;
	reg [7:0] next_rdata;
	wire [STAB_W-1:0] stab_limit;
	wire [7:0] thr_hit;

	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr = req & wb_we_i & wb_sel_i;
	assign wb_err_o = 1'b0;

	always @(posedge mclk)
	begin
		if (rst)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= req;
	end

	// ----------------------------------------------------------------
	// Write-once oscillator mode
	// ----------------------------------------------------------------
	always @(posedge mclk)
	begin
		if (rst)
		begin
			mode_written <= 1'b0;
			osc_mode_config <= 8'h00;
			main_osc_high_gain <= 1'b0;
		end
		else if (wr && wb_adr_i == `CGC_OFS_MODE && !mode_written)
		begin
			mode_written <= 1'b1;
			osc_mode_config <= wb_dat_i;
			main_osc_high_gain <= wb_dat_i[`CGC_MODE_HIGH_GAIN];
		end
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	always @(posedge mclk)
	begin
		if (rst)
		begin
			run_stop <= `CGC_RST_RUNSTOP;
			stab_sel <= `CGC_RST_STAB_SEL;
			sysclk <= `CGC_RST_SYSCLK;
			fast_internal_enable <= 1'b0;
			fast_internal_select <= 1'b0;
			flash_speed_mode <= 1'b0;
			flash_low_power_mode <= 1'b0;
			sub_halt_low_power <= 1'b0;
			regulator_mode <= `CGC_REG_NORMAL;
			rtc_clock_enable <= 1'b0;
			peripheral_enable <= 7'h00;
		end
		else if (wr)
		begin
			case (wb_adr_i)
				`CGC_OFS_RUNSTOP: run_stop <= wb_dat_i;
				`CGC_OFS_STAB_SEL: stab_sel <= {5'h00, wb_dat_i[2:0]};
				`CGC_OFS_SYSCLK: sysclk <= wb_dat_i;
				`CGC_OFS_FAST_OSC:
				begin
					fast_internal_enable <= wb_dat_i[`CGC_FO_ENABLE];
					fast_internal_select <= wb_dat_i[`CGC_FO_SELECT];
				end
				`CGC_OFS_SPEED:
				begin
					flash_speed_mode <= wb_dat_i[`CGC_SP_FLASH_SPEED];
					flash_low_power_mode <= flash_low_power_mode |
						wb_dat_i[`CGC_SP_FLASH_LOW];
					sub_halt_low_power <= wb_dat_i[`CGC_SP_SUB_HALT_LP];
				end
				`CGC_OFS_REGULATOR: regulator_mode <= wb_dat_i;
				`CGC_OFS_PERIPH:
				begin
					rtc_clock_enable <= wb_dat_i[`CGC_PE_RTC];
					peripheral_enable <= wb_dat_i[6:0];
				end
				default: ;
			endcase
		end
	end

	always @*
	begin
		main_osc_stop = run_stop[`CGC_RS_MAIN_STOP];
		sub_osc_stop = run_stop[`CGC_RS_SUB_STOP];
		internal_osc_stop = run_stop[`CGC_RS_INT_STOP];
		// one clock for CPU and peripherals
		cpu_source_select = sysclk[`CGC_CK_CPU_SRC];
		main_source_select = sysclk[`CGC_CK_MAIN_SEL];
		main_divider_field = sysclk[`CGC_CK_DIV_HI:`CGC_CK_DIV_LO];
		// only RTC in low-power sub HALT
		periph_clock_enable = ~(sub_halt & sub_halt_low_power);
	end

	// ----------------------------------------------------------------
	// Stabilization counter
	// ----------------------------------------------------------------
	// Threshold n is 2^(8+n) main oscillator ticks; selection caps the count
	assign stab_limit = {{(STAB_W-1){1'b0}}, 1'b1} << (5'd8 + {2'b00, stab_sel[2:0]});

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1)
		begin : g_thr
			assign thr_hit[gi] = stab_count >= ({{(STAB_W-1){1'b0}}, 1'b1} << (8 + gi));
		end
	endgenerate

	always @(posedge mclk)
	begin
		// Stopped oscillator or STOP release restarts the wait
		if (rst || main_osc_stop || stop_release)
		begin
			stab_count <= {STAB_W{1'b0}};
			stab_status <= 8'h00;
		end
		else
		begin
			if (main_osc_tick && stab_count < stab_limit)
				stab_count <= stab_count + {{(STAB_W-1){1'b0}}, 1'b1};
			stab_status <= stab_status | thr_hit;
		end
	end

	// ----------------------------------------------------------------
	// CPU stall on flash speed write
	// ----------------------------------------------------------------
	// Half-cycle stall rounded up: CPU waits one whole extra clock
	always @(posedge mclk)
	begin
		if (rst)
			stall_count <= 9'd0;
		else if (wr && wb_adr_i == `CGC_OFS_SPEED && wb_dat_i[`CGC_SP_FLASH_SPEED])
			stall_count <= `CGC_STALL_CYCLES;
		else if (stall_count != 9'd0)
			stall_count <= stall_count - 9'd1;
	end

	assign cpu_stall = stall_count != 9'd0;

	// ----------------------------------------------------------------
	// Read back
	// ----------------------------------------------------------------
	always @*
	begin
		next_rdata = 8'h00;
		case (wb_adr_i)
			`CGC_OFS_MODE: next_rdata = osc_mode_config;
			`CGC_OFS_RUNSTOP: next_rdata = run_stop;
			`CGC_OFS_STAB_STATUS: next_rdata = stab_status;
			`CGC_OFS_STAB_SEL: next_rdata = stab_sel;
			`CGC_OFS_SYSCLK: next_rdata = sysclk;
			`CGC_OFS_FAST_OSC: next_rdata = {6'h00, fast_internal_select, fast_internal_enable};
			`CGC_OFS_SPEED: next_rdata = {sub_halt_low_power, 5'h00,
				flash_low_power_mode, flash_speed_mode};
			`CGC_OFS_REGULATOR: next_rdata = regulator_mode;
			`CGC_OFS_PERIPH: next_rdata = {rtc_clock_enable, peripheral_enable};
			`CGC_OFS_STATUS: next_rdata = {6'h00, cpu_stall, mode_written};
			default: next_rdata = 8'h00;
		endcase
	end

	always @(posedge mclk)
	begin
		if (rst)
			wb_dat_o <= 8'h00;
		else if (req)
			wb_dat_o <= next_rdata;
	end

endmodule // cgc_clock_generator_control
